// ---- shared/ccd_seq_defines.vh ----
`ifndef CCD_SEQ_DEFINES_VH
`define CCD_SEQ_DEFINES_VH
// ***********************************************
// Line layout in horizontal positions
// ***********************************************
`define LEAD_DARK        8
`define LEAD_TEST        1
`define LEAD_IDLE        3
`define DARK_REF         34
`define ACTIVE_PIX       2184
`define TRAIL_DARK       34
`define TRAIL_TEST       1
`define TRAIL_IDLE       2
`define HORIZ_LEN        2267
// ***********************************************
// Frame layout in rows
// ***********************************************
`define FRAME_ROWS       1510
`define TOP_DARK_ROWS    34
`define BOTTOM_DARK_ROWS 4
// ***********************************************
// Timing in clock cycles at 100 MHz
// ***********************************************
`define CLK_PERIOD_NS    10
`define VPHASE_NS        5000
`define VPHASE_CYC       (`VPHASE_NS / `CLK_PERIOD_NS)
`define HSETUP_NS        1000
`define HSETUP_CYC       (`HSETUP_NS / `CLK_PERIOD_NS)
`define HHALF_CYC        5
`define RESET_CYC        2
`endif

// ---- rtl/ccd_readout_ctrl.v ----
`timescale 1ns/1ns
`include "ccd_seq_defines.vh"
module ccd_readout_ctrl
#(
   parameter VPHASE_CYC = `VPHASE_CYC,
   parameter HSETUP_CYC = `HSETUP_CYC,
   parameter HHALF_CYC  = `HHALF_CYC,
   parameter ROWS       = `FRAME_ROWS,
   parameter HLEN       = `HORIZ_LEN
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Command
   input  wire        exposeReq,
   input  wire        readoutReq,
   // Status
   output reg         busy_r,
   output reg         frameDone_r,
   // Sensor clock pins
   output reg         vertPhaseA_r,
   output reg         vertPhaseB_r,
   output reg         horizPhaseA_r,
   output reg         horizPhaseB_r,
   output reg         resetClk_r,
   // Sampling strobe and pixel tags
   output reg         sampleStrobe_r,
   output reg  [2:0]  pixClass_r,
   output reg         darkRow_r,
   output reg  [11:0] pixIndex_r,
   output reg  [10:0] rowIndex_r
);
   // ***********************************************
   // States
   // ***********************************************
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_V1   = 7'h02;
   localparam [6:0] ST_V2   = 7'h04;
   localparam [6:0] ST_V3   = 7'h08;
   localparam [6:0] ST_HSET = 7'h10;
   localparam [6:0] ST_HLO  = 7'h20;
   localparam [6:0] ST_HHI  = 7'h40;
   // Pixel classes
   localparam [2:0] PC_IDLE   = 3'h0;
   localparam [2:0] PC_TEST   = 3'h1;
   localparam [2:0] PC_DARK   = 3'h2;
   localparam [2:0] PC_ACTIVE = 3'h3;
   localparam [2:0] PC_DUMMY  = 3'h4;
   // Cumulative boundaries of the line layout
   localparam B0 = `LEAD_DARK;
   localparam B1 = B0 + `LEAD_TEST;
   localparam B2 = B1 + `LEAD_IDLE;
   localparam B3 = B2 + `DARK_REF;
   localparam B4 = B3 + `ACTIVE_PIX;
   localparam B5 = B4 + `TRAIL_DARK;
   localparam B6 = B5 + `TRAIL_TEST;

   reg [6:0]  state_r;   // Sequencer state
   reg [15:0] tmr_r;     // Phase timer
   reg [11:0] hCnt_r;    // Horizontal shifts done
   reg [10:0] vCnt_r;    // Rows transferred

   // ***********************************************
   // Position classifier
   // ***********************************************
   function [2:0] classOf;
      input [11:0] p;
      begin
         if (p < B0)
            classOf = PC_DUMMY;
         else if (p < B1)
            classOf = PC_TEST;
         else if (p < B2)
            classOf = PC_IDLE;
         else if (p < B3)
            classOf = PC_DARK;
         else if (p < B4)
            classOf = PC_ACTIVE;
         else if (p < B5)
            classOf = PC_DARK;
         else if (p < B6)
            classOf = PC_TEST;
         else
            classOf = PC_IDLE;
      end
   endfunction

   // Dark row test
   function isDarkRow;
      input [10:0] r;
      begin
         isDarkRow = (r < `TOP_DARK_ROWS) || (r >= ROWS - `BOTTOM_DARK_ROWS);
      end
   endfunction

   // ***********************************************
   // Sequencer
   // ***********************************************
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r        <= ST_IDLE;
         tmr_r          <= 16'h0000;
         hCnt_r         <= 12'h000;
         vCnt_r         <= 11'h000;
         busy_r         <= 1'b0;
         frameDone_r    <= 1'b0;
         vertPhaseA_r   <= 1'b0;
         vertPhaseB_r   <= 1'b0;
         horizPhaseA_r  <= 1'b0;
         horizPhaseB_r  <= 1'b1;
         resetClk_r     <= 1'b0;
         sampleStrobe_r <= 1'b0;
         pixClass_r     <= 3'h0;
         darkRow_r      <= 1'b0;
         pixIndex_r     <= 12'h000;
         rowIndex_r     <= 11'h000;
      end
      else
      begin
         frameDone_r    <= 1'b0;
         sampleStrobe_r <= 1'b0;
         resetClk_r     <= 1'b0;
         case (state_r)
            // Exposure or idle: vertical phases low
            ST_IDLE:
            begin
               vertPhaseA_r  <= 1'b0;
               vertPhaseB_r  <= 1'b0;
               horizPhaseA_r <= 1'b0;
               horizPhaseB_r <= 1'b1;
               busy_r        <= 1'b0;
               if (readoutReq && !exposeReq)
               begin
                  busy_r  <= 1'b1;
                  vCnt_r  <= 11'h000;
                  tmr_r   <= 16'h0000;
                  state_r <= ST_V1;
               end
            end
            // Vertical A high, B low
            ST_V1:
            begin
               vertPhaseA_r  <= 1'b1;
               vertPhaseB_r  <= 1'b0;
               horizPhaseB_r <= 1'b1;
               horizPhaseA_r <= 1'b0;
               tmr_r <= tmr_r + 16'h0001;
               if (tmr_r == VPHASE_CYC - 1)
               begin
                  tmr_r   <= 16'h0000;
                  state_r <= ST_V2;
               end
            end
            // Both high
            ST_V2:
            begin
               vertPhaseB_r <= 1'b1;
               tmr_r <= tmr_r + 16'h0001;
               if (tmr_r == VPHASE_CYC - 1)
               begin
                  tmr_r   <= 16'h0000;
                  state_r <= ST_V3;
               end
            end
            // Vertical A falls: row enters horizontal register
            ST_V3:
            begin
               vertPhaseA_r <= 1'b0;
               tmr_r <= tmr_r + 16'h0001;
               if (tmr_r == VPHASE_CYC - 1)
               begin
                  vertPhaseB_r <= 1'b0;
                  tmr_r        <= 16'h0000;
                  hCnt_r       <= 12'h000;
                  rowIndex_r   <= vCnt_r;
                  darkRow_r    <= isDarkRow(vCnt_r);
                  state_r      <= ST_HSET;
               end
            end
            // Setup before horizontal shifting
            ST_HSET:
            begin
               tmr_r <= tmr_r + 16'h0001;
               if (tmr_r == HSETUP_CYC - 1)
               begin
                  tmr_r         <= 16'h0000;
                  horizPhaseA_r <= 1'b1;
                  horizPhaseB_r <= 1'b0;
                  state_r       <= ST_HHI;
               end
            end
            // Horizontal A high half
            ST_HHI:
            begin
               tmr_r <= tmr_r + 16'h0001;
               if (tmr_r == HHALF_CYC - 1)
               begin
                  tmr_r         <= 16'h0000;
                  horizPhaseA_r <= 1'b0;
                  horizPhaseB_r <= 1'b1;
                  state_r       <= ST_HLO;
               end
            end
            // Horizontal A low half: sample, then reset node
            ST_HLO:
            begin
               tmr_r <= tmr_r + 16'h0001;
               if (tmr_r == 16'h0001)
               begin
                  sampleStrobe_r <= 1'b1;
                  pixIndex_r     <= hCnt_r;
                  pixClass_r     <= classOf(hCnt_r);
               end
               if (tmr_r == 16'h0002)
                  resetClk_r <= 1'b1;
               if (tmr_r == HHALF_CYC - 1)
               begin
                  tmr_r  <= 16'h0000;
                  hCnt_r <= hCnt_r + 12'h001;
                  if (hCnt_r == HLEN - 1)
                  begin
                     vCnt_r <= vCnt_r + 11'h001;
                     if (vCnt_r == ROWS - 1)
                     begin
                        frameDone_r <= 1'b1;
                        busy_r      <= 1'b0;
                        state_r     <= ST_IDLE;
                     end
                     else
                        state_r <= ST_V1;
                  end
                  else
                  begin
                     horizPhaseA_r <= 1'b1;
                     horizPhaseB_r <= 1'b0;
                     state_r       <= ST_HHI;
                  end
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // ccd_readout_ctrl

// ---- testbench/ccd_readout_ctrl_asserts.sv ----
`timescale 1ns/1ns
// ***********************
// Readout controller checks
// ***********************
module ccd_readout_ctrl_asserts
#(parameter VPHASE_CYC = 4, HSETUP_CYC = 4, HHALF_CYC = 4, ROWS = 5, HLEN = 2267)
(
   // Clock, reset, command
   input wire        clk,
   input wire        rst_n,
   input wire        exposeReq,
   // Status and clock pins
   input wire        busy_r,
   input wire        frameDone_r,
   input wire        vertPhaseA_r,
   input wire        vertPhaseB_r,
   input wire        horizPhaseA_r,
   input wire        horizPhaseB_r,
   input wire        resetClk_r,
   // Sampling
   input wire        sampleStrobe_r,
   input wire [11:0] pixIndex_r,
   input wire [10:0] rowIndex_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_horiz_not_both: assert property (!(horizPhaseA_r && horizPhaseB_r)) else $error("phase overlap");
   a_horiz_compl: assert property (horizPhaseA_r != horizPhaseB_r) else $error("phases not complementary");
   a_idle_vert_low: assert property (!busy_r |-> !vertPhaseA_r && !vertPhaseB_r) else $error("idle vert");
   a_expose_blocks: assert property (!busy_r && exposeReq && $past(exposeReq) |=> !busy_r)
      else $error("start in expose");
   a_start_vert: assert property ($rose(busy_r) |-> ##[1:2] $rose(vertPhaseA_r)) else $error("no row move");
   a_row_load_hb: assert property ($fell(vertPhaseA_r) |-> horizPhaseB_r) else $error("load with B low");
   a_fall_strobe: assert property ($fell(horizPhaseA_r) |-> ##2 sampleStrobe_r) else $error("no sample");
   a_strobe_reset: assert property (sampleStrobe_r |=> resetClk_r && !sampleStrobe_r) else $error("no reset");
   a_done_last: assert property (frameDone_r |-> rowIndex_r == ROWS - 1 && pixIndex_r == HLEN - 1)
      else $error("early done");
endmodule // ccd_readout_ctrl_asserts
bind ccd_readout_ctrl ccd_readout_ctrl_asserts #(.VPHASE_CYC(VPHASE_CYC), .HSETUP_CYC(HSETUP_CYC),
   .HHALF_CYC(HHALF_CYC), .ROWS(ROWS), .HLEN(HLEN)) chk (.clk, .rst_n, .exposeReq, .busy_r, .frameDone_r,
   .vertPhaseA_r, .vertPhaseB_r, .horizPhaseA_r, .horizPhaseB_r, .resetClk_r, .sampleStrobe_r, .pixIndex_r, .rowIndex_r);

// ---- testbench/ccd_sensor_model.sv ----
`timescale 1ns/1ns
// ***********
// Sensor side
// ***********
module ccd_sensor_model
#(parameter HLEN = 2267, ROWS = 1510)
(
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   // Clock pins
   input wire        vertA,
   input wire        horizA,
   input wire        horizB,
   // Packet position, row, bad load
   output reg [11:0] pos,
   output reg [10:0] row,
   output reg        loadErr,
   // Class of the packet now at the output, dark row flag
   output wire [2:0] posClass,
   output wire       rowDark
);
   reg vPrev;
   reg hPrev;
   // Class of a position: 4 lead dummy, 1 test, 0 idle, 2 dark, 3 image
   function [2:0] cls(input [11:0] p);
      cls = p < 8 ? 3'h4 : p == 8 ? 3'h1 : p < 12 ? 3'h0 : p < 46 ? 3'h2 :
            p < 2230 ? 3'h3 : p < 2264 ? 3'h2 : p == 2264 ? 3'h1 : 3'h0;
   endfunction
   // Layout of the packet now sensed, and whether its row is shielded
   assign posClass = cls(pos);
   assign rowDark  = (row < 11'h022) || (row >= ROWS - 4);
   // Row loads on vertical A fall, packets on horizontal A fall
   always @(posedge clk)
   begin
      vPrev <= vertA;
      hPrev <= horizA;
      if (!rst_n)
         {pos, row, loadErr} <= {12'hFFF, 11'h7FF, 1'b0};
      else if (vPrev && !vertA)
      begin
         loadErr <= loadErr | !horizB | (row != 11'h7FF && pos != HLEN - 1);
         {row, pos} <= {row + 11'h001, 12'hFFF};
      end
      else if (hPrev && !horizA)
         pos <= pos + 12'h001;
   end
endmodule // ccd_sensor_model

// ---- testbench/ccd_readout_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin failCount++; $display("[ERR] %0t mismatch %0h %0h", $time, a, b); end end
module ccd_readout_ctrl_tb_top;
   reg         clk;
   reg         rst_n;
   reg         exposeReq;
   reg         readoutReq;
   wire        busy_r, frameDone_r, vertPhaseA_r, vertPhaseB_r, horizPhaseA_r, horizPhaseB_r, resetClk_r;
   wire        sampleStrobe_r, darkRow_r, loadErr, rowDark;
   wire [2:0]  pixClass_r, posClass;
   wire [11:0] pixIndex_r, pos;
   wire [10:0] rowIndex_r, row;
   reg  [2:0]  got [0:2266];
   reg  [14:0] tbl [0:13];
   integer     failCount, nChecks, i;
   ccd_readout_ctrl #(.VPHASE_CYC(4), .HSETUP_CYC(4), .HHALF_CYC(4), .ROWS(5), .HLEN(2267)) dut (.clk, .rst_n,
      .exposeReq, .readoutReq, .busy_r, .frameDone_r, .vertPhaseA_r, .vertPhaseB_r, .horizPhaseA_r, .horizPhaseB_r,
      .resetClk_r, .sampleStrobe_r, .pixClass_r, .darkRow_r, .pixIndex_r, .rowIndex_r);
   ccd_sensor_model sensor (.clk, .rst_n, .vertA(vertPhaseA_r), .horizA(horizPhaseA_r),
      .horizB(horizPhaseB_r), .pos, .row, .loadErr, .posClass, .rowDark);
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Every sample against the sensor's own count
   always @(negedge clk)
      if (sampleStrobe_r === 1'b1)
      begin
         got[pixIndex_r] = pixClass_r;
         `CHK(pixIndex_r, pos)
         `CHK(pixClass_r, posClass)
         `CHK(rowIndex_r, row)
         `CHK(darkRow_r, rowDark)
      end
   // Counts, verdict, stop
   task endOfTest;
   begin
      $display("checks %0d errors %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   // Rows: position and the class it must carry
   initial
   begin
      tbl = '{15'h0004, 15'h003C, 15'h0041, 15'h0048, 15'h0058, 15'h0062, 15'h016A, 15'h0173,
              15'h45AB, 15'h45B2, 15'h46BA, 15'h46C1, 15'h46C8, 15'h46D0};
      failCount = 0;
      nChecks = 0;
      {rst_n, exposeReq, readoutReq} = 3'h3;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      `CHK({busy_r, vertPhaseA_r, horizPhaseA_r, horizPhaseB_r}, 4'h1)
      // Refused while exposing
      repeat (8) @(negedge clk);
      `CHK({busy_r, vertPhaseA_r, vertPhaseB_r}, 3'h0)
      // Start, then reset during the row move
      exposeReq = 1'b0;
      @(negedge clk);
      readoutReq = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({busy_r, vertPhaseA_r}, 2'h3)
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({busy_r, vertPhaseA_r, vertPhaseB_r, horizPhaseB_r}, 4'h1)
      rst_n = 1'b1;
      // Whole frame
      readoutReq = 1'b1;
      @(negedge clk);
      readoutReq = 1'b0;
      for (i = 0; i < 95000 && frameDone_r !== 1'b1; i++)
         @(negedge clk);
      `CHK(i < 95000, 1'b1)
      `CHK({loadErr, row, pos}, {1'b0, 11'h004, 12'h8DA})
      repeat (2) @(negedge clk);
      `CHK(busy_r, 1'b0)
      for (i = 0; i < 14; i++)
         `CHK(got[tbl[i][14:3]], tbl[i][2:0])
      endOfTest;
   end
endmodule // ccd_readout_ctrl_tb_top
